// ==== isc_pkg.sv ====
/*
 * Constants, register offsets, field positions and vectors for the interrupt source controller.
 * Assumes an APB master with 32-bit data; every register takes one aligned word.
 */
// Operation
// RL1: Accept requests from twenty-one event sources.
// RL2: Vector core to fixed address per source.
// RL3: Standard vectors eight bytes apart, 03 to 63.
// RL4: All auxiliary sources share vector 33.
// RL5: Auxiliary sources set one flag, own enable.
// RL6: Auxiliary group always top priority.
// RL7: Same level ties resolved by natural order.
// RL8: Flags examined in natural order.
// RL9: Flag requests only while source enabled.
// RL10: Global gate qualifies all non-auxiliary enables.
// RL11: One high/low priority bit per source.
// RL12: Edge pin flag cleared on vectoring.
// RL13: Level pin flag follows the pin.
// RL14: Timer 0/1 flags cleared on vectoring.
// RL15: Timer flags set on rollover regardless.
// RL16: Serial requests on rx or tx; no autoclear.
// RL17: Software-set flag triggers like hardware; not auxiliary.
// RL18: Return instruction ends service, releases level.
// RL19: Requests evaluated at every instruction boundary.
// RL20: All enables cleared after reset.
// RL21: Three nesting levels: aux, high, low.
// RL22: Global gate leaves auxiliary group alone.
// RL23: Pins 2-5 pending in extended flag bits 4-7.
package isc_pkg;
   localparam int NUM_SRC = 12;
   localparam int NUM_AUX = 9;
   // Byte addresses of the registers.
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BASE_EN    = 8'h04;
   localparam logic [7:0] ADDR_BASE_PRI   = 8'h08;
   localparam logic [7:0] ADDR_EXT_FLAG   = 8'h0C;
   localparam logic [7:0] ADDR_EXT_EN     = 8'h10;
   localparam logic [7:0] ADDR_EXT_PRI    = 8'h14;
   localparam logic [7:0] ADDR_EXTRA_CTRL = 8'h18;
   localparam logic [7:0] ADDR_AUX_EN     = 8'h1C;
   localparam logic [7:0] ADDR_AUX_STAT   = 8'h20;
   localparam logic [7:0] ADDR_SERIAL     = 8'h24;
   localparam logic [7:0] ADDR_MODE       = 8'h28;
   localparam logic [7:0] ADDR_STATUS     = 8'h2C;
   // Field positions.
   localparam int TC_PIN0  = 1;
   localparam int TC_PIN1  = 3;
   localparam int TC_TMR0  = 5;
   localparam int TC_TMR1  = 7;
   localparam int EN_GLOBAL = 7;
   localparam int EC_AUX_EN   = 5;
   localparam int EC_AUX_FLAG = 4;
   localparam int EC_WDOG     = 3;
   localparam int EC_FILL     = 6;
   localparam int XF_PIN2  = 4;
   localparam int SER_TMR2 = 4;
   // Source index in natural order, 0 is pin 0.
   localparam int S_PIN0 = 0;
   localparam int S_TMR0 = 1;
   localparam int S_PIN1 = 2;
   localparam int S_TMR1 = 3;
   localparam int S_SER0 = 4;
   localparam int S_TMR2 = 5;
   localparam int S_SER1 = 6;
   localparam int S_PIN2 = 7;
   localparam int S_WDOG = 11;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [15:0] VEC_AUX  = 16'h0033;
   localparam logic [3:0]  AUX_CODE = 4'hF;
   localparam logic [3:0]  NO_CODE  = 4'hE;
   localparam logic [31:0] FILL_EXT = 32'h000000E0;
   localparam logic [31:0] FILL_EC  = 32'h00000040;
   localparam logic [1:0]  LVL_LOW  = 2'h1;
   localparam logic [1:0]  LVL_HIGH = 2'h2;
   localparam logic [1:0]  LVL_AUX  = 2'h3;
   typedef enum logic [2:0] {
      ISC_IDLE   = 3'b001,
      ISC_ACK    = 3'b010,
      ISC_HOLD   = 3'b100
   } isc_state_e;
endpackage : isc_pkg

// ==== isc_arbiter.sv ====
/*
 * Priority selection among pending, enabled sources.
 * Assumes request and priority vectors are stable within a cycle; purely combinational.
 */
module isc_arbiter
   import isc_pkg::*;
#(
   parameter int N = NUM_SRC
) (
   input  wire logic [N-1:0] req,
   input  wire logic [N-1:0] pri_high,
   input  wire logic         aux_req,
   output logic              win_valid,
   output logic [3:0]        win_code,
   output logic [1:0]        win_level
);
   logic [N-1:0] hi_req;
   logic [N-1:0] lo_req;

   assign hi_req = req & pri_high;
   assign lo_req = req & ~pri_high;

   // ----------------------------------------------------------------
   // Ranking
   // ----------------------------------------------------------------
   always_comb begin
      win_valid = 1'b0;
      win_code  = NO_CODE;
      win_level = 2'h0;
      // RL6: auxiliary ranks first.
      if (aux_req) begin
         win_valid = 1'b1;
         win_code  = AUX_CODE;
         win_level = LVL_AUX;
      end else begin
         // RL7: natural order tie break, scanning downward so the lowest index wins.
         for (int i = N - 1; i >= 0; i--) begin
            if (lo_req[i]) begin
               win_valid = 1'b1;
               win_code  = 4'(i);
               win_level = LVL_LOW;
            end
         end
         // RL11: high bit lifts a source above all low ones.
         for (int i = N - 1; i >= 0; i--) begin
            if (hi_req[i]) begin
               win_valid = 1'b1;
               win_code  = 4'(i);
               win_level = LVL_HIGH;
            end
         end
      end
   end
endmodule : isc_arbiter

// ==== isc_vector_rom.sv ====
/*
 * Maps a winning source code to its code-memory vector.
 * Assumes codes outside the standard range are only the auxiliary code.
 */
module isc_vector_rom
   import isc_pkg::*;
(
   input  wire logic [3:0]  code,
   output logic      [15:0] vector
);
   always_comb begin
      // RL4: one shared auxiliary slot.
      if (code == AUX_CODE) begin
         vector = VEC_AUX;
      end else begin
         // RL3: slots eight bytes apart, skipping the shared auxiliary slot.
         vector = VEC_BASE + VEC_STEP * {12'h000, code};
         if (code >= 4'(S_SER1)) vector = vector + VEC_STEP;
      end
   end
endmodule : isc_vector_rom

// ==== isc_top.sv ====
/*
 * Interrupt source controller: flags, enables, priorities, arbitration, vectoring and nesting.
 * Assumes an APB master, and a core that pulses instr_boundary after every instruction,
 * takes vec_valid with vec_ack and pulses handler_return on the return-from-handler instruction.
 */
module isc_top
   import isc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [5:0]  ext_pin_n,
   input  wire logic [2:0]  timer_rollover,
   input  wire logic        serial0_rx_set,
   input  wire logic        serial0_tx_set,
   input  wire logic        serial1_rx_set,
   input  wire logic        serial1_tx_set,
   input  wire logic        watchdog_event,
   input  wire logic [8:0]  aux_event,
   input  wire logic        instr_boundary,
   input  wire logic        vec_ack,
   input  wire logic        handler_return,
   output logic             vec_valid,
   output logic      [15:0] vec_addr,
   output logic             irq_active
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [5:0]  pin_flag_reg,  pin_flag_next;
   logic [5:0]  pin_prev_reg,  pin_prev_next;
   logic [5:0]  pin_edge_reg,  pin_edge_next;
   logic [2:0]  tmr_flag_reg,  tmr_flag_next;
   logic [3:0]  ser_flag_reg,  ser_flag_next;
   logic        wdog_flag_reg, wdog_flag_next;
   logic [8:0]  aux_stat_reg,  aux_stat_next;
   logic [8:0]  aux_en_reg,    aux_en_next;
   logic        aux_gen_reg,   aux_gen_next;
   logic [7:0]  base_en_reg,   base_en_next;
   logic [6:0]  base_pri_reg,  base_pri_next;
   logic [4:0]  ext_en_reg,    ext_en_next;
   logic [4:0]  ext_pri_reg,   ext_pri_next;
   logic [2:0]  in_svc_reg,    in_svc_next;
   logic [3:0]  code_reg,      code_next;
   logic [15:0] vec_reg,       vec_next;
   logic [31:0] rdata_reg,     rdata_next;
   isc_state_e  state_reg,     state_next;

   logic [NUM_SRC-1:0] flags, enables, pri_bits, req;
   logic [5:0]  pin_lvl, pin_view;
   logic        aux_flag, aux_req;
   logic        win_valid;
   logic [3:0]  win_code;
   logic [1:0]  win_level;
   logic [15:0] win_vec;
   logic [1:0]  cur_level;
   logic        wr, rd, acked;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pin_lvl = ~ext_pin_n;

   // RL5: any auxiliary status sets the common flag.
   assign aux_flag = |aux_stat_reg;
   // RL22: auxiliary gated only by its own enable.
   assign aux_req  = aux_flag & aux_gen_reg;

   // RL13: level mode shows the pin directly.
   for (genvar g = 0; g < 6; g++) begin : g_pin
      assign pin_view[g] = pin_edge_reg[g] ? pin_flag_reg[g] : pin_lvl[g];
   end

   // RL8: flags gathered in natural order.
   assign flags = {wdog_flag_reg,
                   pin_view[5:2],
                   ser_flag_reg[3] | ser_flag_reg[2],
                   tmr_flag_reg[2],
                   ser_flag_reg[1] | ser_flag_reg[0],
                   tmr_flag_reg[1],
                   pin_view[1],
                   tmr_flag_reg[0],
                   pin_view[0]};
   assign enables = {ext_en_reg[4:0], base_en_reg[6], base_en_reg[5], base_en_reg[4],
                     base_en_reg[3], base_en_reg[2], base_en_reg[1], base_en_reg[0]};
   assign pri_bits = {ext_pri_reg, base_pri_reg};

   // RL9: enable bit required per source.
   // RL10: global gate on every non-auxiliary source.
   assign req = flags & enables & {NUM_SRC{base_en_reg[EN_GLOBAL]}};

   // RL21: current service level blocks equal or lower requests.
   always_comb begin
      cur_level = 2'h0;
      if (in_svc_reg[0]) cur_level = LVL_LOW;
      if (in_svc_reg[1]) cur_level = LVL_HIGH;
      if (in_svc_reg[2]) cur_level = LVL_AUX;
   end

   isc_arbiter #(.N(NUM_SRC)) u_arb (
      .req       (req),
      .pri_high  (pri_bits),
      .aux_req   (aux_req),
      .win_valid (win_valid),
      .win_code  (win_code),
      .win_level (win_level)
   );

   isc_vector_rom u_rom (
      .code   (win_code),
      .vector (win_vec)
   );

   assign acked = (state_reg == ISC_ACK) & vec_ack;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      pin_prev_next  = pin_lvl;
      pin_flag_next  = pin_flag_reg;
      pin_edge_next  = pin_edge_reg;
      tmr_flag_next  = tmr_flag_reg;
      ser_flag_next  = ser_flag_reg;
      wdog_flag_next = wdog_flag_reg;
      aux_stat_next  = aux_stat_reg;
      aux_en_next    = aux_en_reg;
      aux_gen_next   = aux_gen_reg;
      base_en_next   = base_en_reg;
      base_pri_next  = base_pri_reg;
      ext_en_next    = ext_en_reg;
      ext_pri_next   = ext_pri_reg;
      in_svc_next    = in_svc_reg;
      code_next      = code_reg;
      vec_next       = vec_reg;
      state_next     = state_reg;
      rdata_next     = rdata_reg;

      // Software writes first; hardware events below override so a set is never lost.
      if (wr) begin
         case (paddr)
            ADDR_TIMER_CTRL: begin
               pin_edge_next[0] = pwdata[TC_PIN0-1];
               pin_edge_next[1] = pwdata[TC_PIN1-1];
               // RL17: software may set flags directly.
               pin_flag_next[0] = pwdata[TC_PIN0];
               pin_flag_next[1] = pwdata[TC_PIN1];
               tmr_flag_next[0] = pwdata[TC_TMR0];
               tmr_flag_next[1] = pwdata[TC_TMR1];
            end
            ADDR_BASE_EN:    base_en_next  = pwdata[7:0];
            ADDR_BASE_PRI:   base_pri_next = pwdata[6:0];
            ADDR_EXT_FLAG:   pin_flag_next[5:2] = pwdata[XF_PIN2+3:XF_PIN2];
            ADDR_EXT_EN:     ext_en_next  = pwdata[4:0];
            ADDR_EXT_PRI:    ext_pri_next = pwdata[4:0];
            ADDR_EXTRA_CTRL: begin
               aux_gen_next   = pwdata[EC_AUX_EN];
               wdog_flag_next = pwdata[EC_WDOG];
            end
            ADDR_AUX_EN:     aux_en_next = pwdata[8:0];
            // Auxiliary status is write-one-to-clear only, never settable.
            ADDR_AUX_STAT:   aux_stat_next = aux_stat_reg & ~pwdata[8:0];
            ADDR_SERIAL: begin
               ser_flag_next    = pwdata[3:0];
               tmr_flag_next[2] = pwdata[SER_TMR2];
            end
            ADDR_MODE:       pin_edge_next[5:2] = pwdata[5:2];
            default: ;
         endcase
      end

      // RL12: edge-mode pin flag cleared on vectoring.
      // RL14: timer 0/1 flags cleared on vectoring.
      if (acked) begin
         if (code_reg == 4'(S_PIN0)) pin_flag_next[0] = 1'b0;
         if (code_reg == 4'(S_PIN1)) pin_flag_next[1] = 1'b0;
         if (code_reg == 4'(S_TMR0)) tmr_flag_next[0] = 1'b0;
         if (code_reg == 4'(S_TMR1)) tmr_flag_next[1] = 1'b0;
         if (code_reg >= 4'(S_PIN2) && code_reg < 4'(S_WDOG))
            pin_flag_next[code_reg - 4'(S_PIN2) + 2] = 1'b0;
      end

      // RL1: hardware event capture, wins over any clear.
      for (int i = 0; i < 6; i++) begin
         if (pin_edge_reg[i] & pin_lvl[i] & ~pin_prev_reg[i]) pin_flag_next[i] = 1'b1;
      end
      // RL15: rollover sets flag independent of enables.
      tmr_flag_next = tmr_flag_next | timer_rollover;
      // RL16: either rx or tx requests; software clears.
      ser_flag_next = ser_flag_next | {serial1_tx_set, serial1_rx_set,
                                       serial0_tx_set, serial0_rx_set};
      if (watchdog_event) wdog_flag_next = 1'b1;
      aux_stat_next = aux_stat_next | (aux_event & aux_en_reg);

      // RL2: vector handshake with the core.
      case (state_reg)
         ISC_IDLE: begin
            // RL19: decide only at an instruction boundary.
            if (instr_boundary && win_valid && (win_level > cur_level)) begin
               code_next  = win_code;
               vec_next   = win_vec;
               state_next = ISC_ACK;
            end
         end
         ISC_ACK: begin
            if (vec_ack) begin
               in_svc_next[win_level_idx(code_reg)] = 1'b1;
               state_next = ISC_HOLD;
            end
         end
         ISC_HOLD: state_next = ISC_IDLE;
         default:  state_next = ISC_IDLE;
      endcase

      // RL18: return releases the highest active level.
      if (handler_return) begin
         if (in_svc_reg[2])      in_svc_next[2] = 1'b0;
         else if (in_svc_reg[1]) in_svc_next[1] = 1'b0;
         else                    in_svc_next[0] = 1'b0;
      end

      if (rd) begin
         case (paddr)
            ADDR_TIMER_CTRL: rdata_next = {24'h0, tmr_flag_reg[1], 1'b0, tmr_flag_reg[0], 1'b0,
                                           flags[S_PIN1], pin_edge_reg[1],
                                           flags[S_PIN0], pin_edge_reg[0]};
            ADDR_BASE_EN:    rdata_next = {24'h0, base_en_reg};
            ADDR_BASE_PRI:   rdata_next = {25'h0, base_pri_reg};
            // RL23: pins 2-5 pending in upper nibble.
            ADDR_EXT_FLAG:   rdata_next = {24'h0, pin_view[5:2], 4'h0};
            ADDR_EXT_EN:     rdata_next = FILL_EXT | {27'h0, ext_en_reg};
            ADDR_EXT_PRI:    rdata_next = FILL_EXT | {27'h0, ext_pri_reg};
            ADDR_EXTRA_CTRL: rdata_next = FILL_EC | {26'h0, aux_gen_reg, aux_flag,
                                                     wdog_flag_reg, 3'h0};
            ADDR_AUX_EN:     rdata_next = {23'h0, aux_en_reg};
            ADDR_AUX_STAT:   rdata_next = {23'h0, aux_stat_reg};
            ADDR_SERIAL:     rdata_next = {27'h0, tmr_flag_reg[2], ser_flag_reg};
            ADDR_MODE:       rdata_next = {26'h0, pin_edge_reg};
            ADDR_STATUS:     rdata_next = {24'h0, in_svc_reg, code_reg, state_reg == ISC_ACK};
            default:         rdata_next = 32'h0;
         endcase
      end
   end

   function automatic logic [1:0] win_level_idx(input logic [3:0] c);
      if (c == AUX_CODE) return 2'h2;
      else if (pri_bits[c]) return 2'h1;
      else return 2'h0;
   endfunction : win_level_idx

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_flag_reg  <= 6'h00;
         pin_prev_reg  <= 6'h00;
         pin_edge_reg  <= 6'h00;
         tmr_flag_reg  <= 3'h0;
         ser_flag_reg  <= 4'h0;
         wdog_flag_reg <= 1'b0;
         aux_stat_reg  <= 9'h000;
         // RL20: all enables clear out of reset.
         aux_en_reg    <= 9'h000;
         aux_gen_reg   <= 1'b0;
         base_en_reg   <= 8'h00;
         base_pri_reg  <= 7'h00;
         ext_en_reg    <= 5'h00;
         ext_pri_reg   <= 5'h00;
         in_svc_reg    <= 3'h0;
         code_reg      <= NO_CODE;
         vec_reg       <= 16'h0000;
         rdata_reg     <= 32'h0;
         state_reg     <= ISC_IDLE;
      end else begin
         pin_flag_reg  <= pin_flag_next;
         pin_prev_reg  <= pin_prev_next;
         pin_edge_reg  <= pin_edge_next;
         tmr_flag_reg  <= tmr_flag_next;
         ser_flag_reg  <= ser_flag_next;
         wdog_flag_reg <= wdog_flag_next;
         aux_stat_reg  <= aux_stat_next;
         aux_en_reg    <= aux_en_next;
         aux_gen_reg   <= aux_gen_next;
         base_en_reg   <= base_en_next;
         base_pri_reg  <= base_pri_next;
         ext_en_reg    <= ext_en_next;
         ext_pri_reg   <= ext_pri_next;
         in_svc_reg    <= in_svc_next;
         code_reg      <= code_next;
         vec_reg       <= vec_next;
         rdata_reg     <= rdata_next;
         state_reg     <= state_next;
      end
   end

   always_comb begin
      prdata = rdata_next;
      if (!rd) prdata = 32'h0;
   end
   assign pslverr    = 1'b0;
   assign vec_valid  = (state_reg == ISC_ACK);
   assign vec_addr   = vec_reg;
   assign irq_active = |in_svc_reg;
endmodule : isc_top

// ==== isc_core_model.sv ====
/*
 * Core model facing isc_top: instruction boundaries, vector acks, handler returns.
 * Assumes vec_valid stands until acked.
 */
module isc_core_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        vec_valid,
   input  wire logic [15:0] vec_addr,
   input  wire logic        ack_slow,
   input  wire logic        hold_ret,
   output logic             instr_boundary,
   output logic             vec_ack,
   output logic             handler_return,
   output logic      [15:0] last_vec,
   output logic      [7:0]  vec_count,
   output logic      [2:0]  depth
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_c;
   logic [2:0] run_c;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {instr_boundary, vec_ack, handler_return} <= '0;
         {last_vec, vec_count, depth, wait_c, run_c} <= '0;
      end else begin
         instr_boundary <= !instr_boundary;
         vec_ack        <= 1'b0;
         handler_return <= 1'b0;
         if (vec_valid && !vec_ack) begin
            wait_c  <= wait_c + 2'd1;
            vec_ack <= !ack_slow || wait_c == 2'd3;
         end
         if (vec_valid && vec_ack) begin
            last_vec  <= vec_addr;
            vec_count <= vec_count + 8'd1;
            depth     <= depth + 3'd1;
            run_c     <= 3'd4;
            wait_c    <= 2'd0;
         end else if (depth != 3'd0 && !hold_ret && !vec_valid && instr_boundary) begin
            if (run_c == 3'd0) begin
               handler_return <= 1'b1;
               depth          <= depth - 3'd1;
               run_c          <= 3'd4;
            end else begin
               run_c <= run_c - 3'd1;
            end
         end
      end
   end
endmodule : isc_core_model

// ==== isc_top_assertions.sv ====
/*
 * Port checker for isc_top.
 * Bound to every isc_top instance; single clock domain.
 */
module isc_top_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        instr_boundary,
   input wire logic        vec_ack,
   input wire logic        handler_return,
   input wire logic        vec_valid,
   input wire logic [15:0] vec_addr,
   input wire logic        irq_active
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_zero_wait; psel && penable |-> pready && !pslverr; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("bus answer late");
   property p_ack_hold; vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr); endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("vector dropped");
   property p_vec_addr; vec_valid |-> vec_addr[2:0] == 3'h3 && vec_addr <= 16'h0063; endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
   property p_rst_quiet; $rose(presetn) |-> !vec_valid && !irq_active; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("busy at reset");
   property p_ack_active; vec_valid && vec_ack |=> irq_active && !vec_valid; endproperty
   a_ack_active: assert property (p_ack_active) else $error("no service");
   property p_taken; $rose(vec_valid) |-> $past(instr_boundary); endproperty
   a_taken: assert property (p_taken) else $error("off boundary");
   property p_gap; vec_valid && vec_ack |=> !vec_valid [*2]; endproperty
   a_gap: assert property (p_gap) else $error("no hold cycle");
   property p_keep; irq_active && !handler_return |=> irq_active; endproperty
   a_keep: assert property (p_keep) else $error("service lost");
endmodule : isc_top_assertions

bind isc_top isc_top_assertions i_isc_top_assertions (.*);

// ==== isc_top_tb.sv ====
/*
 * Self-checking bench of isc_top over APB with the core model.
 * Assumes zero-wait APB.
 */
module isc_top_tb;
   import isc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, vec_count;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [5:0]  ext_pin_n;
   logic [2:0]  timer_rollover, depth;
   logic [8:0]  aux_event;
   logic        serial0_rx_set, serial0_tx_set, serial1_rx_set, serial1_tx_set;
   logic        watchdog_event, instr_boundary, vec_ack, handler_return;
   logic        vec_valid, irq_active, ack_slow, hold_ret;
   logic [15:0] vec_addr, last_vec;
   int          fail_count, tests_run;

   isc_top i_isc_top (.*);
   isc_core_model i_isc_core_model (.*);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [31:0] pin_mask(input int i);
      return 32'h1 << ((i == 0) ? TC_PIN0 : (i == 1) ? TC_PIN1 : XF_PIN2 + i - 2);
   endfunction : pin_mask
   function automatic logic [15:0] vec_of(input int s);
      return 16'(VEC_BASE + VEC_STEP * 16'(s + ((s >= S_SER1) ? 1 : 0)));
   endfunction : vec_of

   task automatic conclude;
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic expire;
      fail_count++;
      $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 0, 1);
      conclude();
   endtask : expire
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) expire();
      rd = prdata;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rdchk
   task automatic pulse(input logic [16:0] ev);
      {aux_event, watchdog_event, serial1_tx_set, serial1_rx_set, serial0_tx_set,
       serial0_rx_set, timer_rollover} <= ev;
      @(posedge pclk);
      {aux_event, watchdog_event, timer_rollover} <= '0;
      {serial1_tx_set, serial1_rx_set, serial0_tx_set, serial0_rx_set} <= '0;
   endtask : pulse
   task automatic wait_vec(input logic [15:0] e);
      int n;
      logic [7:0] c0;
      c0 = vec_count;
      for (n = 0; vec_count === c0 && n < 300; n++) @(posedge pclk);
      if (n >= 300) expire();
      chk({16'h0, last_vec}, {16'h0, e});
   endtask : wait_vec
   task automatic quiet;
      logic [7:0] c0;
      c0 = vec_count;
      repeat (40) @(posedge pclk);
      chk({24'h0, vec_count}, {24'h0, c0});
   endtask : quiet
   task automatic drain;
      int n;
      for (n = 0; (depth !== 3'd0 || irq_active !== 1'b0) && n < 300; n++) @(posedge pclk);
      if (n >= 300) expire();
   endtask : drain
   // Serial flags never clear themselves, so the handler is held while software clears them.
   task automatic clr_ser(input logic [31:0] m);
      hold_ret <= 1'b1;
      rdchk(ADDR_SERIAL, m, m);
      apb(1'b1, ADDR_SERIAL, 32'h0);
      hold_ret <= 1'b0;
      drain();
   endtask : clr_ser

   initial begin
      {psel, penable, pwrite, paddr, pwdata, ack_slow, hold_ret} = '0;
      {aux_event, watchdog_event, timer_rollover} = '0;
      {serial1_tx_set, serial1_rx_set, serial0_tx_set, serial0_rx_set} = '0;
      ext_pin_n = 6'h3F;
      presetn = 1'b0;
      fail_count = 0;
      tests_run = 0;
      seed = 32'hA9BB;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(ADDR_BASE_EN, 32'hFF, 32'h0);
      rdchk(ADDR_EXT_EN, 32'hFF, FILL_EXT);
      rdchk(ADDR_EXTRA_CTRL, 32'hFF, FILL_EC);
      rdchk(ADDR_AUX_EN, 32'h1FF, 32'h0);
      rdchk(8'h40, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 6; i++) begin
         ext_pin_n[i] <= 1'b0;
         repeat (3) @(posedge pclk);
         rdchk(i < 2 ? ADDR_TIMER_CTRL : ADDR_EXT_FLAG, pin_mask(i), pin_mask(i));
         ext_pin_n[i] <= 1'b1;
         repeat (3) @(posedge pclk);
         rdchk(i < 2 ? ADDR_TIMER_CTRL : ADDR_EXT_FLAG, pin_mask(i), 32'h0);
      end
      pulse(17'h00001);
      rdchk(ADDR_TIMER_CTRL, 32'h20, 32'h20);
      apb(1'b1, ADDR_BASE_EN, 32'h02);
      quiet();
      apb(1'b1, ADDR_BASE_EN, 32'h82);
      wait_vec(vec_of(S_TMR0));
      drain();
      rdchk(ADDR_TIMER_CTRL, 32'h20, 32'h0);
      apb(1'b1, ADDR_TIMER_CTRL, 32'h20);
      wait_vec(vec_of(S_TMR0));
      drain();
      ack_slow <= 1'b1;
      apb(1'b1, ADDR_BASE_EN, 32'hFF);
      pulse(17'h0000A);
      wait_vec(vec_of(S_TMR1));
      wait_vec(vec_of(S_SER0));
      clr_ser(32'h1);
      apb(1'b1, ADDR_SERIAL, 32'h8);
      wait_vec(vec_of(S_SER1));
      clr_ser(32'h8);
      ack_slow <= 1'b0;
      apb(1'b1, ADDR_TIMER_CTRL, 32'h1);
      ext_pin_n[0] <= 1'b0;
      wait_vec(vec_of(S_PIN0));
      drain();
      rdchk(ADDR_TIMER_CTRL, 32'h2, 32'h0);
      ext_pin_n[0] <= 1'b1;
      apb(1'b1, ADDR_BASE_EN, 32'hC2);
      apb(1'b1, ADDR_BASE_PRI, 32'h40);
      hold_ret <= 1'b1;
      pulse(17'h00001);
      wait_vec(vec_of(S_TMR0));
      pulse(17'h00040);
      wait_vec(vec_of(S_SER1));
      apb(1'b1, ADDR_AUX_EN, 32'h10);
      apb(1'b1, ADDR_EXTRA_CTRL, 32'h20);
      apb(1'b1, ADDR_BASE_EN, 32'h42);
      pulse(17'h01000);
      wait_vec(VEC_AUX);
      rdchk(ADDR_EXTRA_CTRL, 32'h10, 32'h10);
      pulse(17'h01000);
      quiet();
      apb(1'b1, ADDR_AUX_STAT, 32'h1FF);
      apb(1'b1, ADDR_SERIAL, 32'h0);
      hold_ret <= 1'b0;
      drain();
      pulse(17'h000B0);
      rdchk(ADDR_EXTRA_CTRL, 32'h8, 32'h8);
      rdchk(ADDR_SERIAL, 32'hF, 32'h6);
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         apb(1'b1, ADDR_BASE_PRI, {25'h0, seed[6:0]});
         rdchk(ADDR_BASE_PRI, 32'h7F, {25'h0, seed[6:0]});
         apb(1'b1, ADDR_AUX_EN, {23'h0, seed[24:16]});
         rdchk(ADDR_AUX_EN, 32'h1FF, {23'h0, seed[24:16]});
      end
      conclude();
   end
endmodule : isc_top_tb
